// ### core/ehm_clk_div.v
// Management clock divider: turns the select code into a half period and toggles the clock
`timescale 1ns/1ps
module ehm_clk_div (
  clk_sys,
  reset,
  hold,
  sel,
  mdc_o,
  rise_o,
  fall_o
);
  input wire clk_sys;
  input wire reset;
  input wire hold;
  input wire [3:0] sel;
  output reg mdc_o;
  output reg rise_o;
  output reg fall_o;

  reg [4:0] half_w;
  reg [4:0] cnt_r;

  always @* begin
    case (sel)
      4'h0, 4'h1: half_w = 5'h02;
      4'h2: half_w = 5'h03;
      4'h3: half_w = 5'h04;
      4'h4: half_w = 5'h05;
      4'h5: half_w = 5'h07;
      4'h6: half_w = 5'h0a;
      4'h7: half_w = 5'h0e;
      4'h8: half_w = 5'h14;
      4'h9: half_w = 5'h18;
      4'ha: half_w = 5'h19;
      // Undefined codes fall back to the slowest rate, the safest for any PHY
      default: half_w = 5'h19;
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r <= 5'h00;
      mdc_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else if (hold) begin
      cnt_r <= 5'h00;
      mdc_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else if (cnt_r >= half_w - 5'h01) begin
      cnt_r <= 5'h00;
      mdc_o <= ~mdc_o;
      rise_o <= ~mdc_o;
      fall_o <= mdc_o;
    end else begin
      cnt_r <= cnt_r + 5'h01;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
  end
endmodule // ehm_clk_div

// ### core/ehm_defs.vh
// Register offsets, field positions, reset values and timing constants for the hash table and management config
`ifndef EHM_DEFS_VH
`define EHM_DEFS_VH

// Word offsets (byte addresses) of the registers and their set/clear/invert aliases
`define EHM_OFS_HT_LOW 8'h00
`define EHM_OFS_HT_HIGH 8'h10
`define EHM_OFS_MCFG 8'h20
`define EHM_OFS_RXCTL 8'h30
`define EHM_OFS_STAT 8'h40
`define EHM_ALIAS_CLR 2'h1
`define EHM_ALIAS_SET 2'h2
`define EHM_ALIAS_INV 2'h3

// Management configuration fields
`define EHM_MCFG_RST_BIT 15
`define EHM_MCFG_SEL_HI 5
`define EHM_MCFG_SEL_LO 2
`define EHM_MCFG_SUPPRESS_PREAMBLE_BIT 1
`define EHM_MCFG_SCAN_BIT 0
`define EHM_MCFG_MASK 32'h0000803f
`define EHM_MCFG_RESET 32'h00000020

// Receive control fields
`define EHM_RX_EN_BIT 0
`define EHM_RX_HASH_FILTER_ENABLE_BIT 1
`define EHM_RX_PHY_LO 8
`define EHM_RX_PHY_HI 12
`define EHM_RX_MASK 32'h00001f03
`define EHM_RX_RESET 32'h00000001

// Management frame
`define EHM_PREAMBLE_BITS 7'h20
`define EHM_FRAME_BITS 7'h20
`define EHM_MII_REG_ADDR 5'h01

`endif

// ### core/ehm_hash_filter.v
// Receive hash lookup: one table bit per destination hash index
`timescale 1ns/1ps
module ehm_hash_filter (
  clk_sys,
  reset,
  table_i,
  enable_i,
  idx_valid,
  idx,
  hit_o
);
  input wire clk_sys;
  input wire reset;
  input wire [63:0] table_i;
  input wire enable_i;
  input wire idx_valid;
  input wire [5:0] idx;
  output reg hit_o;

  always @(posedge clk_sys or posedge reset) begin
    if (reset)
      hit_o <= 1'b0;
    else
      hit_o <= idx_valid & enable_i & table_i[idx];
  end
endmodule // ehm_hash_filter

// ### core/ehm_top.v
// Hash table and management configuration registers with the management serial engine
//
// Behaviour
// - 64-bit receive hash table in two words, bytes 0-3 low, bytes 4-7 high.
// - Hash table only steers receive filtering, never transmit.
// - Management soft reset bit set holds the management engine in reset.
// - Suppress preamble drops the 32-bit preamble from management cycles.
// - Scan increment reads PHY 1 up to the target address, else one PHY repeatedly.
// - Divider select 000x/0010/0011/0100 divide by 4/6/8/10.
// - Select 0101..1010 divide by 14/20/28/40/48/50; other codes undefined.
// - 16- and 32-bit accesses work, aliases too; 8-bit accesses ignored.
// - Config bits 31-16 and 14-6 read as zero.
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ehm_defs.vh"
module ehm_top (
  clk_sys,
  reset,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  rx_hash_valid,
  rx_hash_index,
  rx_hash_hit,
  mdc,
  mdio_i,
  mdio_o,
  mdio_oe,
  scan_data,
  scan_phy,
  scan_valid
);
  input wire clk_sys;
  input wire reset;
  input wire [7:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  input wire [3:0] avs_byteenable;
  output reg [31:0] avs_readdata;
  output reg avs_waitrequest;
  input wire rx_hash_valid;
  input wire [5:0] rx_hash_index;
  output wire rx_hash_hit;
  output reg mdc;
  input wire mdio_i;
  output reg mdio_o;
  output reg mdio_oe;
  output reg [15:0] scan_data;
  output reg [4:0] scan_phy;
  output reg scan_valid;

  localparam ST_IDLE = 4'b0001;
  localparam ST_PRE = 4'b0010;
  localparam ST_HDR = 4'b0100;
  localparam ST_DATA = 4'b1000;

  ////////////////////////////////////////////////////////////////////////
  // Register bus

  reg [31:0] ht_low_r;
  reg [31:0] ht_high_r;
  reg [31:0] mcfg_r;
  reg [31:0] rxctl_r;
  reg ack_r;
  reg [31:0] wmask;
  reg [31:0] cur;
  reg [31:0] wval;
  reg [31:0] rd_nxt;
  reg sel_ok;
  wire [1:0] alias_w;
  wire [7:0] base_w;
  wire size_ok;
  wire req;
  wire [4:0] stat_phy;
  wire busy;

  assign alias_w = avs_address[3:2];
  assign base_w = {avs_address[7:4], 4'h0};
  assign req = (avs_read | avs_write) & ~ack_r;
  // Only whole halfwords or the whole word count; single bytes are dropped
  assign size_ok = (avs_byteenable == 4'hf) | (avs_byteenable == 4'h3) | (avs_byteenable == 4'hc);

  always @* begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    sel_ok = 1'b1;
    case (base_w)
      `EHM_OFS_HT_LOW: cur = ht_low_r;
      `EHM_OFS_HT_HIGH: cur = ht_high_r;
      `EHM_OFS_MCFG: cur = mcfg_r;
      `EHM_OFS_RXCTL: cur = rxctl_r;
      `EHM_OFS_STAT: cur = {26'h0000000, stat_phy, busy};
      default: begin
        cur = 32'h00000000;
        sel_ok = 1'b0;
      end
    endcase
    case (alias_w)
      `EHM_ALIAS_CLR: wval = cur & ~(avs_writedata & wmask);
      `EHM_ALIAS_SET: wval = cur | (avs_writedata & wmask);
      `EHM_ALIAS_INV: wval = cur ^ (avs_writedata & wmask);
      default: wval = (cur & ~wmask) | (avs_writedata & wmask);
    endcase
    rd_nxt = (sel_ok & size_ok) ? cur : 32'h00000000;
  end

  wire wr_go;
  // The write lands at the edge where the master sees waitrequest low, so an alias is applied once
  assign wr_go = ack_r & avs_write & size_ok;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ht_low_r <= 32'h00000000;
      ht_high_r <= 32'h00000000;
      mcfg_r <= `EHM_MCFG_RESET;
      rxctl_r <= `EHM_RX_RESET;
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      // One wait cycle: the request is answered on the second edge after it rises
      ack_r <= req;
      avs_waitrequest <= ~req;
      if (req & avs_read)
        avs_readdata <= rd_nxt;
      if (wr_go) begin
        case (base_w)
          `EHM_OFS_HT_LOW: ht_low_r <= wval;
          `EHM_OFS_HT_HIGH: ht_high_r <= wval;
          `EHM_OFS_MCFG: mcfg_r <= wval & `EHM_MCFG_MASK;
          `EHM_OFS_RXCTL: rxctl_r <= wval & `EHM_RX_MASK;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive hash filter

  wire hash_en;
  assign hash_en = rxctl_r[`EHM_RX_HASH_FILTER_ENABLE_BIT] & rxctl_r[`EHM_RX_EN_BIT];

  ehm_hash_filter u_hash (
    .clk_sys(clk_sys),
    .reset(reset),
    .table_i({ht_high_r, ht_low_r}),
    .enable_i(hash_en),
    .idx_valid(rx_hash_valid),
    .idx(rx_hash_index),
    .hit_o(rx_hash_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Management clock and scanning read engine

  wire mgmt_rst;
  wire mdc_w;
  wire rise_w;
  wire fall_w;
  wire [4:0] tgt_phy;
  assign mgmt_rst = mcfg_r[`EHM_MCFG_RST_BIT];
  assign tgt_phy = rxctl_r[`EHM_RX_PHY_HI:`EHM_RX_PHY_LO];

  ehm_clk_div u_div (
    .clk_sys(clk_sys),
    .reset(reset),
    .hold(mgmt_rst),
    .sel(mcfg_r[`EHM_MCFG_SEL_HI:`EHM_MCFG_SEL_LO]),
    .mdc_o(mdc_w),
    .rise_o(rise_w),
    .fall_o(fall_w)
  );

  reg [3:0] st_r;
  reg [6:0] bit_r;
  reg [4:0] phy_r;
  reg [15:0] shreg_r;
  reg [31:0] frame_r;
  wire [4:0] next_phy;
  assign busy = ~st_r[0];
  assign stat_phy = phy_r;
  // Address 0 is a broadcast on many PHYs, so a scan never visits it
  assign next_phy = (~mcfg_r[`EHM_MCFG_SCAN_BIT] | (phy_r >= tgt_phy)) ?
    (mcfg_r[`EHM_MCFG_SCAN_BIT] ? 5'h01 : tgt_phy) : phy_r + 5'h01;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= ST_IDLE;
      bit_r <= 7'h00;
      phy_r <= 5'h00;
      shreg_r <= 16'h0000;
      frame_r <= 32'h00000000;
      mdc <= 1'b0;
      mdio_o <= 1'b1;
      mdio_oe <= 1'b0;
      scan_data <= 16'h0000;
      scan_phy <= 5'h00;
      scan_valid <= 1'b0;
    end else if (mgmt_rst) begin
      st_r <= ST_IDLE;
      bit_r <= 7'h00;
      phy_r <= 5'h00;
      mdc <= 1'b0;
      mdio_o <= 1'b1;
      mdio_oe <= 1'b0;
      scan_valid <= 1'b0;
    end else begin
      mdc <= mdc_w;
      scan_valid <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (fall_w) begin
            phy_r <= next_phy;
            // Read frame: start, read op, PHY, register, turnaround
            frame_r <= {2'b01, 2'b10, next_phy, `EHM_MII_REG_ADDR, 2'b11, 16'h0000};
            bit_r <= 7'h00;
            // Line stays released for this one bit, so the preamble holds exactly 32 ones
            mdio_oe <= 1'b0;
            mdio_o <= 1'b1;
            st_r <= mcfg_r[`EHM_MCFG_SUPPRESS_PREAMBLE_BIT] ? ST_HDR : ST_PRE;
          end
        end
        ST_PRE: begin
          if (fall_w) begin
            mdio_oe <= 1'b1;
            mdio_o <= 1'b1;
            if (bit_r == `EHM_PREAMBLE_BITS - 7'h01) begin
              bit_r <= 7'h00;
              st_r <= ST_HDR;
            end else
              bit_r <= bit_r + 7'h01;
          end
        end
        ST_HDR: begin
          if (fall_w) begin
            mdio_o <= frame_r[31];
            frame_r <= {frame_r[30:0], 1'b0};
            // Release the line for the turnaround and the PHY's data
            mdio_oe <= (bit_r < 7'h0e);
            // One fall past the turnaround, so the first data rise samples bit 16
            if (bit_r == 7'h10) begin
              bit_r <= 7'h00;
              st_r <= ST_DATA;
            end else
              bit_r <= bit_r + 7'h01;
          end
        end
        ST_DATA: begin
          mdio_oe <= 1'b0;
          if (rise_w) begin
            shreg_r <= {shreg_r[14:0], mdio_i};
            if (bit_r == 7'h0f) begin
              scan_data <= {shreg_r[14:0], mdio_i};
              scan_phy <= phy_r;
              scan_valid <= 1'b1;
              bit_r <= 7'h00;
              st_r <= ST_IDLE;
            end else
              bit_r <= bit_r + 7'h01;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule // ehm_top

// ### sim/ehm_phy_model.sv
// Management PHY model answering read frames
`timescale 1ns/1ps
module ehm_phy_model (
  input wire mdc,
  input wire mdio_o,
  input wire mdio_oe,
  input wire clr,
  output logic phy_o,
  output logic phy_oe,
  output int pre_n
);
  int cnt = 0;
  int pre_c = 0;
  logic [4:0] phy = 5'h0;
  // Read data carries the PHY address so the bench can tell PHYs apart
  wire [15:0] rdat = {11'h528, phy};
  initial begin
    pre_n = 0;
    phy_oe = 1'b0;
    phy_o = 1'b1;
  end
  ////////////////////
  always @(posedge mdc or posedge clr) begin
    if (clr) begin
      cnt = 0;
      pre_c = 0;
    end else if (cnt > 0) begin
      cnt = (cnt + 1) % 32;
      if (cnt >= 5 && cnt <= 9) phy = {phy[3:0], mdio_o};
    end else if (mdio_oe && mdio_o) pre_c++;
    else if (mdio_oe) begin
      cnt = 1;
      pre_n = pre_c;
      pre_c = 0;
    end
  end
  // Change on the falling edge so data is stable around the sampling rise
  always @(negedge mdc) begin
    phy_oe <= cnt >= 15;
    phy_o <= cnt < 16 ? 1'b0 : rdat[31 - cnt];
  end
endmodule // ehm_phy_model

// ### sim/ehm_top_asserts.sv
// Bus, hash and management clock checks for ehm_top
`timescale 1ns/1ps
module ehm_top_asserts (
  input wire clk_sys,
  input wire reset,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire rx_hash_valid,
  input wire rx_hash_hit,
  input wire mdc,
  input wire scan_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire req = avs_read | avs_write;
  wire rd_ans = avs_read & ~avs_waitrequest;
  wire be_ok = avs_byteenable == 4'hf || avs_byteenable == 4'h3 || avs_byteenable == 4'hc;
  ////////////////////
  sequence s_pending;
    req && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer: assert property (s_pending |=> s_answer)
    else $error("bus answer");
  chk_bus_quiet: assert property (!req |=> avs_waitrequest)
    else $error("bus spurious");
  chk_byte_drop: assert property (rd_ans && !be_ok |-> avs_readdata == 32'h0)
    else $error("byte read");
  chk_cfg_zero: assert property (rd_ans && avs_address[7:4] == 4'h2 |->
    avs_readdata[31:16] == 16'h0 && avs_readdata[14:6] == 9'h0) else $error("cfg bits");
  chk_hit_cause: assert property (rx_hash_hit |-> $past(rx_hash_valid))
    else $error("hash hit");
  chk_mdc_high: assert property ($rose(mdc) && !avs_write && !$past(avs_write) |=> mdc)
    else $error("mdc high");
  chk_mdc_low: assert property ($fell(mdc) |=> !mdc)
    else $error("mdc low");
  chk_scan_pulse: assert property (scan_valid |=> !scan_valid)
    else $error("scan pulse");
endmodule // ehm_top_asserts
bind ehm_top ehm_top_asserts u_chk (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .rx_hash_valid, .rx_hash_hit, .mdc, .scan_valid);

// ### sim/eth_rx_hash_and_mii_mgmt_config_bench.sv
// Bench for the hash table and management configuration block
`timescale 1ns/1ps
module eth_rx_hash_and_mii_mgmt_config_bench;
  logic clk_sys, reset, avs_read, avs_write, rx_hash_valid, clr;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [5:0] rx_hash_index;
  logic [15:0] scan_data;
  logic [4:0] scan_phy;
  wire avs_waitrequest, rx_hash_hit, mdc, mdio_o, mdio_oe, scan_valid, phy_o, phy_oe;
  int error_cnt, cmp_count, cyc, n, pre_n;
  typedef struct {logic [7:0] a; logic [3:0] b; logic [31:0] d, e;} ehm_row_t;
  ehm_row_t rows [10] = '{'{8'h00, 4'hf, 32'h80000001, 32'h80000001},
    '{8'h10, 4'hf, 32'h100, 32'h100}, '{8'h10, 4'hc, 32'h10000, 32'h10100},
    '{8'h10, 4'h1, 32'hffffffff, 32'h10100}, '{8'h20, 4'hf, 32'hffffffff, 32'h803f},
    '{8'h20, 4'h3, 32'h0, 32'h0}, '{8'h28, 4'hf, 32'h1, 32'h1}, '{8'h2c, 4'hf, 32'h8001, 32'h8000},
    '{8'h24, 4'hf, 32'h8000, 32'h0}, '{8'h50, 4'hf, 32'hffff, 32'h0}};
  int divs [11] = '{4, 4, 6, 8, 10, 14, 20, 28, 40, 48, 50};
  int hidx [7] = '{0, 31, 40, 48, 1, 63, 32};
  logic hexp [7] = '{1, 1, 1, 1, 0, 0, 0};
  // Data line has a pull-up: released reads high
  wire mdio_i = mdio_oe ? mdio_o : phy_oe ? phy_o : 1'b1;
  ehm_top uut (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .rx_hash_valid, .rx_hash_index, .rx_hash_hit, .mdc, .mdio_i,
    .mdio_o, .mdio_oe, .scan_data, .scan_phy, .scan_valid);
  ehm_phy_model u_phy (.mdc, .mdio_o, .mdio_oe, .clr, .phy_o, .phy_oe, .pre_n);
  ////////////////////
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic rd, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_byteenable <= b;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wsv;
    do tick(); while (scan_valid !== 1'b1);
  endtask
  task automatic rise;
    n = 0;
    while (mdc !== 1'b0) begin
      tick();
      n++;
    end
    while (mdc !== 1'b1) begin
      tick();
      n++;
    end
  endtask
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    rx_hash_valid = 1'b0;
    rx_hash_index = 6'h0;
    clr = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      bus(1, 8'(i * 16), 4'hf, 0);
      chk("reset_value", i == 2 ? 32'h20 : 32'h0, q);
    end
    foreach (rows[i]) begin
      bus(0, rows[i].a, rows[i].b, rows[i].d);
      bus(1, rows[i].a & 8'hf0, 4'hf, 0);
      chk("reg_row", rows[i].e, q);
    end
    bus(1, 8'h10, 4'h1, 0);
    chk("byte_read", 32'h0, q);
    foreach (divs[i]) begin
      bus(0, 8'h20, 4'hf, 32'(i) << 2);
      rise();
      rise();
      rise();
      chk("mdc_period", divs[i], n);
    end
    for (int p = 0; p < 2; p++) begin
      bus(0, 8'h30, 4'hf, p ? 32'h301 : 32'h303);
      foreach (hidx[i]) begin
        @(posedge clk_sys);
        rx_hash_valid <= 1'b1;
        rx_hash_index <= 6'(hidx[i]);
        @(posedge clk_sys);
        rx_hash_valid <= 1'b0;
        #1 chk("hash_hit", hexp[i] & !p, rx_hash_hit);
      end
    end
    // Frames run at divide by 20, 12.5 MHz, the fastest rate a tolerant PHY takes
    bus(0, 8'h20, 4'hf, 32'h8018);
    clr <= 1'b1;
    repeat (64) begin
      tick();
      chk("mgmt_idle", 0, {mdc, mdio_oe});
    end
    bus(0, 8'h20, 4'hf, 32'h18);
    clr <= 1'b0;
    wsv();
    wsv();
    chk("scan_phy", 3, scan_phy);
    chk("scan_data", 32'ha503, scan_data);
    chk("preamble", 32, pre_n);
    bus(0, 8'h20, 4'hf, 32'h801b);
    clr <= 1'b1;
    bus(0, 8'h20, 4'hf, 32'h1b);
    clr <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wsv();
      chk("scan_phy", k % 3 + 1, scan_phy);
      chk("preamble", 0, pre_n);
    end
    end_sim();
  end
endmodule // eth_rx_hash_and_mii_mgmt_config_bench
